// ==== core/pad_config_context_save.sv ====
// pad configuration bank with a save engine that copies it into a
// scratchpad before OFF mode and restores it on OFF exit.
// assumes a single-cycle register port with read data one cycle later.
//
// Contract
// - save request copies every pad register
// - OFF exit restores pad registers from scratchpad
// - dual register holds both trace pads
// - divider select bit 2: 0 div4, 1 div2
// - writing save start bit 1 begins save
// - dual register and saved copy fixed addresses
`timescale 1ns/1ps
module pad_config_context_save
    import pad_save_pkg::*;
#(
    parameter int NUM_PADS = NUM_PADS_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic off_exit,
    output logic save_done_flag,
    output logic irq
);

    // the bank is laid out so the dual register is its last word
    localparam int IW = $clog2(NUM_PADS);
    localparam logic [31:0] SPAN = 32'(4 * NUM_PADS);
    localparam logic [31:0] PAD_BASE = DUAL_PAD_ADDR - 32'(4 * (NUM_PADS - 1));
    localparam logic [31:0] SAVE_BASE = DUAL_SAVE_ADDR - 32'(4 * (NUM_PADS - 1));
    // index of the dual register in both banks
    localparam logic [IW-1:0] LAST_IDX = IW'(NUM_PADS - 1);

    initial begin
        if (NUM_PADS < 2 || NUM_PADS > 64) begin
            $error("pad_config_context_save: NUM_PADS must be 2 to 64");
        end
        // the pad bank and its copy must stay clear of each other and of the
        // control words, or one decode would shadow another
        if (PAD_BASE < SAVE_BASE + SPAN && SAVE_BASE < PAD_BASE + SPAN) begin
            $error("pad_config_context_save: pad bank overlaps scratchpad");
        end
        if (IRQ_ENABLE_ADDR >= PAD_BASE && SAVE_CTRL_ADDR < PAD_BASE + SPAN) begin
            $error("pad_config_context_save: pad bank overlaps control words");
        end
        if (IRQ_ENABLE_ADDR >= SAVE_BASE && SAVE_CTRL_ADDR < SAVE_BASE + SPAN) begin
            $error("pad_config_context_save: scratchpad overlaps control words");
        end
        if (IRQ_SAVE_BIT >= IRQ_W || IRQ_RESTORE_BIT >= IRQ_W) begin
            $error("pad_config_context_save: interrupt bit outside status width");
        end
    end

    // =========================================================
    // address decode
    // =========================================================
    logic [31:0] pad_off;
    logic [31:0] save_off;
    logic pad_hit;
    logic save_hit;
    logic ctrl_hit;
    logic stat_hit;
    logic clr_hit;
    logic en_hit;
    logic [IW-1:0] pad_idx;
    logic [IW-1:0] save_idx;
    logic ctrl_wr;
    logic clr_wr;
    logic en_wr;
    logic [NUM_PADS-1:0] pad_bus_we;
    logic [NUM_PADS-1:0] pad_rst_we;
    logic engine_busy;

    assign pad_off = addr - PAD_BASE;
    assign save_off = addr - SAVE_BASE;
    // the dual register sits last in the pad bank and in the scratchpad
    assign pad_hit = (pad_off < SPAN) && (addr[1:0] == 2'h0);
    assign save_hit = (save_off < SPAN) && (addr[1:0] == 2'h0);
    assign ctrl_hit = (addr == SAVE_CTRL_ADDR);
    assign stat_hit = (addr == IRQ_STATUS_ADDR);
    assign clr_hit = (addr == IRQ_CLEAR_ADDR);
    assign en_hit = (addr == IRQ_ENABLE_ADDR);
    assign pad_idx = pad_off[IW+1:2];
    assign save_idx = save_off[IW+1:2];
    // write strobes per target register
    assign ctrl_wr = wr && ctrl_hit;
    assign clr_wr = wr && clr_hit;
    assign en_wr = wr && en_hit;

    // =========================================================
    // state
    // =========================================================
    engine_state_e state_q;
    logic [IW-1:0] idx_q;
    logic phase_q;
    logic div_sel_q;
    logic done_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [31:0] pad_q [NUM_PADS];
    logic [31:0] rdata_q;

    logic tick;
    logic step;
    logic last_step;
    logic start_req;
    logic done_clear;
    logic save_wr;
    logic restore_wr;
    logic save_fin;
    logic restore_fin;
    logic [31:0] scr_rd_a;
    logic [31:0] scr_rd_b;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0] rdata_d;
    logic [31:0] ctrl_view;

    // =========================================================
    // submodules
    // =========================================================
    wakeup_clock_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(engine_busy),
        .wakeup_clock_div_sel(div_sel_q),
        .tick(tick)
    );

    // port b feeds the restore walk, port a the bus read
    pad_scratchpad #(
        .DEPTH(NUM_PADS),
        .WIDTH(32)
    ) u_scr (
        .clk(clk),
        .ce(ce),
        .wr_en(save_wr),
        .wr_idx(idx_q),
        .wr_data(pad_q[idx_q]),
        .rd_idx_a(save_idx),
        .rd_data_a(scr_rd_a),
        .rd_idx_b(idx_q),
        .rd_data_b(scr_rd_b)
    );

    // =========================================================
    // engine control
    // =========================================================
    // the divider only counts while a walk is under way
    assign engine_busy = (state_q != ENG_IDLE);

    // each word takes two ticks: a fetch phase, then the write phase
    assign step = tick && phase_q;
    assign last_step = step && (idx_q == LAST_IDX);
    assign save_wr = (state_q == ENG_SAVE) && step;
    assign restore_wr = (state_q == ENG_RESTORE) && step;
    // done is raised from the write of the last word itself, so a bus
    // access in that cycle cannot cut the walk short
    assign save_fin = save_wr && (idx_q == LAST_IDX);
    assign restore_fin = restore_wr && (idx_q == LAST_IDX);

    // a start is taken only when idle and the previous done is cleared
    assign start_req = ctrl_wr && wdata[CTRL_START_BIT]
        && !engine_busy && !done_q;
    assign done_clear = ctrl_wr && wdata[CTRL_DONE_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ENG_IDLE;
            idx_q <= '0;
            phase_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ENG_IDLE: begin
                    idx_q <= '0;
                    phase_q <= 1'b0;
                    // an OFF exit outranks a save start in the same cycle
                    if (off_exit) begin
                        state_q <= ENG_RESTORE;
                    end else if (start_req) begin
                        state_q <= ENG_SAVE;
                    end
                end
                ENG_SAVE, ENG_RESTORE: begin
                    if (tick) begin
                        phase_q <= !phase_q;
                    end
                    // the index only advances on the write phase
                    if (last_step) begin
                        state_q <= ENG_IDLE;
                        idx_q <= '0;
                    end else if (step) begin
                        idx_q <= idx_q + IW'(1);
                    end
                end
                default: begin
                    state_q <= ENG_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // save control register
    // =========================================================
    // a select written mid-walk is dropped, as is a start; a done clear still acts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_sel_q <= DIV_SEL_RESET;
        end else if (ce && ctrl_wr && !engine_busy) begin
            // divider is frozen while a walk runs
            div_sel_q <= wdata[CTRL_DIV_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (ce) begin
            // set beats a clear in the same cycle
            if (save_fin) begin
                done_q <= 1'b1;
            end else if (done_clear) begin
                done_q <= 1'b0;
            end
        end
    end

    // the flag and control bit 0 are one register
    assign save_done_flag = done_q;

    // =========================================================
    // pad configuration bank
    // =========================================================
    // a restore write wins over a bus write to the same register
    generate
        for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
            // one-hot write enables keep the priority visible per register
            assign pad_rst_we[i] = restore_wr && (idx_q == IW'(i));
            assign pad_bus_we[i] = wr && pad_hit && (pad_idx == IW'(i));
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    pad_q[i] <= PAD_RESET_VAL;
                end else if (ce) begin
                    if (pad_rst_we[i]) begin
                        pad_q[i] <= scr_rd_b;
                    end else if (pad_bus_we[i]) begin
                        pad_q[i] <= wdata;
                    end
                end
            end
        end
    endgenerate

    // =========================================================
    // interrupts
    // =========================================================
    // events that set the sticky status bits
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_SAVE_BIT] = save_fin;
        irq_set[IRQ_RESTORE_BIT] = restore_fin;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else if (ce) begin
            for (int b = 0; b < IRQ_W; b++) begin
                // an event in the cycle of its clear wins
                if (irq_set[b]) begin
                    irq_stat_q[b] <= 1'b1;
                end else if (clr_wr && wdata[b]) begin
                    irq_stat_q[b] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_en_q <= IRQ_ENABLE_RESET;
        end else if (ce && en_wr) begin
            irq_en_q <= wdata[IRQ_W-1:0];
        end
    end

    // level output: any enabled sticky bit
    assign irq = |(irq_stat_q & irq_en_q);

    // =========================================================
    // read port
    // =========================================================
    // control word as software sees it
    always_comb begin
        ctrl_view = 32'h00000000;
        ctrl_view[CTRL_DONE_BIT] = done_q;
        ctrl_view[CTRL_START_BIT] = (state_q == ENG_SAVE);
        ctrl_view[CTRL_DIV_BIT] = div_sel_q;
        ctrl_view[CTRL_RESTORE_BIT] = (state_q == ENG_RESTORE);
    end

    // read data is zero outside the cycle after a read strobe
    always_comb begin
        rdata_d = 32'h00000000;
        if (rd) begin
            if (pad_hit) begin
                rdata_d = pad_q[pad_idx];
            end else if (save_hit) begin
                rdata_d = scr_rd_a;
            end else if (ctrl_hit) begin
                rdata_d = ctrl_view;
            end else if (stat_hit) begin
                rdata_d = {{(32 - IRQ_W){1'b0}}, irq_stat_q};
            end else if (en_hit) begin
                rdata_d = {{(32 - IRQ_W){1'b0}}, irq_en_q};
            end
        end
    end

    // registered so read data stand exactly one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule

// ==== core/pad_save_pkg.sv ====
// constants for the pad configuration save engine: addresses, bit fields,
// reset values and divider counts.
// assumes a 32-bit byte-addressed register port.
package pad_save_pkg;

    // =========================================================
    // register addresses (byte addresses)
    // =========================================================
    localparam logic [31:0] DUAL_PAD_ADDR = 32'h480025f8;
    localparam logic [31:0] DUAL_SAVE_ADDR = 32'h480028dc;
    localparam logic [31:0] SAVE_CTRL_ADDR = 32'h48002400;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h48002404;
    localparam logic [31:0] IRQ_CLEAR_ADDR = 32'h48002408;
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h4800240c;

    // =========================================================
    // save control fields
    // =========================================================
    localparam int CTRL_DONE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_DIV_BIT = 2;
    localparam int CTRL_RESTORE_BIT = 3;

    // =========================================================
    // interrupt fields
    // =========================================================
    localparam int IRQ_W = 2;
    localparam int IRQ_SAVE_BIT = 0;
    localparam int IRQ_RESTORE_BIT = 1;

    // =========================================================
    // reset values and counts
    // =========================================================
    localparam int NUM_PADS_DEFAULT = 8;
    localparam logic [31:0] PAD_RESET_VAL = 32'h00000000;
    localparam logic DIV_SEL_RESET = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 2'h0;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [1:0] DIV2_LAST = 2'h1;

    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_SAVE,
        ENG_RESTORE
    } engine_state_e;

endpackage

// ==== core/pad_scratchpad.sv ====
// scratchpad memory that holds saved pad configuration words.
// assumes one writer (the engine); contents are not reset.
`timescale 1ns/1ps
module pad_scratchpad #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx_a,
    output logic [WIDTH-1:0] rd_data_a,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx_b,
    output logic [WIDTH-1:0] rd_data_b
);

    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2) begin
            $error("pad_scratchpad: DEPTH must be at least 2");
        end
    end

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data_a = mem[rd_idx_a];
    assign rd_data_b = mem[rd_idx_b];

endmodule

// ==== core/wakeup_clock_divider.sv ====
// tick generator for the save engine: one pulse every four or two clocks.
// assumes clk is the peripheral interface clock.
`timescale 1ns/1ps
module wakeup_clock_divider
    import pad_save_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic wakeup_clock_div_sel,
    output logic tick
);

    logic [1:0] cnt_q;
    logic [1:0] last;

    // =========================================================
    // divide by four when select is low, by two when high
    // =========================================================
    assign last = wakeup_clock_div_sel ? DIV2_LAST : DIV4_LAST;
    assign tick = run && (cnt_q == last);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_q <= 2'h0;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

endmodule

// ==== dv/pad_save_sva.sv ====
// checker for the pad save engine, bound to the top module ports.
// assumes ce held high and no control writes during a restore.
`timescale 1ns/1ps
module pad_save_sva
    import pad_save_pkg::*;
#(
    parameter int NUM_PADS = 8
) (
    input logic clk,
    input logic rst_n,
    input logic ce,
    input logic [31:0] addr,
    input logic [31:0] wdata,
    input logic wr,
    input logic rd,
    input logic [31:0] rdata,
    input logic off_exit,
    input logic save_done_flag,
    input logic irq
);
    // =========================================================
    // shadow of save state and enables
    // =========================================================
    logic busy_q, div_q;
    logic [1:0] en_q;
    int cnt_q, lim;
    logic ctrl_wr, go;
    assign ctrl_wr = ce && wr && addr == SAVE_CTRL_ADDR;
    assign go = ctrl_wr && wdata[1] && !busy_q && !save_done_flag && !off_exit;
    assign lim = div_q ? 4 * NUM_PADS : 8 * NUM_PADS;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
        end else if (go) begin
            busy_q <= 1'b1;
            cnt_q <= 0;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q == lim) begin
                busy_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 1'b0;
        end else if (ctrl_wr && !busy_q) begin
            div_q <= wdata[CTRL_DIV_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_q <= 2'h0;
        end else if (ce && wr && addr == IRQ_ENABLE_ADDR) begin
            en_q <= wdata[1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdata_idle;
        !rd |=> rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero when idle");
    property p_done_sticky;
        save_done_flag && !(ctrl_wr && wdata[0]) |=> save_done_flag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done dropped");
    property p_early;
        busy_q && cnt_q < lim |-> !save_done_flag;
    endproperty
    a_early: assert property (p_early) else $error("done before last write");
    property p_on_time;
        busy_q && cnt_q == lim |-> save_done_flag;
    endproperty
    a_on_time: assert property (p_on_time) else $error("done late");
    property p_busy_read;
        rd && addr == SAVE_CTRL_ADDR && busy_q && cnt_q < lim |=> rdata[1] && !rdata[0];
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("start bit not busy");
    property p_done_read;
        rd && addr == SAVE_CTRL_ADDR |=> rdata[0] == $past(save_done_flag);
    endproperty
    a_done_read: assert property (p_done_read) else $error("done bit mismatch");
    property p_irq_mask;
        en_q == 2'h0 |-> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_irq_rise;
        $rose(save_done_flag) && en_q[0] |-> irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq missing");
endmodule

bind pad_config_context_save pad_save_sva #(.NUM_PADS(NUM_PADS)) chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .off_exit(off_exit), .save_done_flag(save_done_flag), .irq(irq)
);

// ==== dv/sw_host.sv ====
// software side: bus master tasks and the guarded save sequence.
// assumes the register port of the save engine.
`timescale 1ns/1ps
module sw_host
    import pad_save_pkg::*;
#(
    parameter int NUM_PADS = 8
) (
    input logic clk,
    output logic [31:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input logic [31:0] rdata
);
    initial begin
        addr = 32'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // =========================================================
    // save with divide by four, quiet wait, poll and compare
    // =========================================================
    task automatic save_seq(output logic ok);
        logic [31:0] d, s, l;
        int ts;
        ts = 2 * 4 * NUM_PADS;
        wr_reg(SAVE_CTRL_ADDR, 32'h2);
        repeat (ts + ts / 10) @(posedge clk);
        d = 32'h0;
        for (int i = 0; i < 50 && d[0] !== 1'b1; i++) rd_reg(SAVE_CTRL_ADDR, d);
        rd_reg(DUAL_SAVE_ADDR, s);
        rd_reg(DUAL_PAD_ADDR, l);
        ok = (s === l);
    endtask
endmodule

// ==== dv/test_pad_config_context_save.sv ====
// self-checking bench for the pad save engine with a software host model.
// assumes the checker is bound from its own file.
`timescale 1ns/1ps
module test_pad_config_context_save;
    import pad_save_pkg::*;
    localparam int N = 4;
    localparam logic [31:0] PAD0 = DUAL_PAD_ADDR - 4 * (N - 1);
    localparam logic [31:0] SCR0 = DUAL_SAVE_ADDR - 4 * (N - 1);
    logic clk = 1'b0, rst_n = 1'b0, off_exit = 1'b0;
    logic [31:0] addr, wdata, rdata, d, seed = 32'h1b7c;
    logic wr, rd, save_done_flag, irq, ok;
    logic [31:0] pad_m [N], scr_m [N];
    int fails = 0, n_compared = 0;
    always #2 clk = ~clk;
    sw_host #(.NUM_PADS(N)) sw (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    pad_config_context_save #(.NUM_PADS(N)) uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .off_exit(off_exit),
        .save_done_flag(save_done_flag), .irq(irq));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        sw.rd_reg(a, d);
        chk(nm, e, d);
    endtask
    task automatic fill_pads();
        for (int i = 0; i < N; i++) begin
            pad_m[i] = xs();
            sw.wr_reg(PAD0 + 4 * i, pad_m[i]);
        end
    endtask
    task automatic chk_copies();
        for (int i = 0; i < N; i++) begin
            scr_m[i] = pad_m[i];
            rchk("scratch", SCR0 + 4 * i, scr_m[i]);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        give_verdict();
    end
    // =========================================================
    // main sequence
    // =========================================================
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl reset", SAVE_CTRL_ADDR, 32'h0);
        rchk("irq enable reset", IRQ_ENABLE_ADDR, 32'h0);
        fill_pads();
        rchk("dual pad", DUAL_PAD_ADDR, pad_m[N-1]);
        sw.wr_reg(IRQ_ENABLE_ADDR, 32'h1);
        sw.save_seq(ok);
        chk("sequence ok", 32'h1, {31'h0, ok});
        chk_copies();
        rchk("dual copy", DUAL_SAVE_ADDR, pad_m[N-1]);
        chk("irq set", 32'h1, {31'h0, irq});
        sw.wr_reg(IRQ_CLEAR_ADDR, 32'h1);
        #1 chk("irq cleared", 32'h0, {31'h0, irq});
        sw.wr_reg(SAVE_CTRL_ADDR, 32'h2);
        rchk("start refused", SAVE_CTRL_ADDR, 32'h1);
        sw.wr_reg(SAVE_CTRL_ADDR, 32'h1);
        rchk("done cleared", SAVE_CTRL_ADDR, 32'h0);
        $display("test save div4 done");
        fill_pads();
        sw.wr_reg(SAVE_CTRL_ADDR, 32'h4);
        sw.wr_reg(SAVE_CTRL_ADDR, 32'h6);
        for (int i = 0; i < 100 && save_done_flag !== 1'b1; i++) begin
            sw.rd_reg(DUAL_PAD_ADDR, d);
        end
        rchk("ctrl div2 done", SAVE_CTRL_ADDR, 32'h5);
        chk_copies();
        sw.wr_reg(SAVE_CTRL_ADDR, 32'h1);
        $display("test save div2 with access done");
        fill_pads();
        @(posedge clk);
        off_exit <= 1'b1;
        @(posedge clk);
        off_exit <= 1'b0;
        repeat (8 * N + 8) @(posedge clk);
        for (int i = 0; i < N; i++) rchk("restored", PAD0 + 4 * i, scr_m[i]);
        rchk("irq status", IRQ_STATUS_ADDR, 32'h3);
        sw.wr_reg(IRQ_ENABLE_ADDR, 32'h0);
        #1 chk("irq masked", 32'h0, {31'h0, irq});
        $display("test restore done");
        sw.wr_reg(32'h0, xs());
        rchk("unmapped", 32'h0, 32'h0);
        $display("test unmapped done");
        give_verdict();
    end
endmodule
